// *** design/vr_pkg.sv ***
// Constants, types and helper functions of the volume ramp and auto-mute block.
// Assumes one system clock; sample periods arrive as one-cycle strobes on it.
// What this block does
// R1: One 8-bit code sets both channel gains
// R2: Code 0x30 is 0 dB, 0xFE is -103 dB
// R3: Code 0xFF fully mutes both channels
// R4: Normal down updates every 1/2/4 periods, or instant
// R5: Normal down step is 4/2/1/0.5 dB
// R6: Up updates every 1/2/4 periods, or instant
// R7: Up step is 4/2/1/0.5 dB
// R8: Emergency down uses its own rate setting
// R9: Emergency down uses its own step setting
// R10: Left auto mute only when bit 0 set
// R11: Right auto mute only when bit 1 set
// R12: Link bit mutes both only when both qualify
// R13: Qualify after programmed run of zero samples
// R14: Ramp stops exactly at target, never overshoots
`default_nettype none
package vr_pkg;
    // Register offsets; 0x70 and 0x71 are read-only state views
    localparam logic [7:0] VR_ADDR_VOLUME  = 8'h4C;
    localparam logic [7:0] VR_ADDR_NORMAL  = 8'h4E;
    localparam logic [7:0] VR_ADDR_EMERG   = 8'h4F;
    localparam logic [7:0] VR_ADDR_AMCTRL  = 8'h50;
    localparam logic [7:0] VR_ADDR_AMTIME  = 8'h51;
    localparam logic [7:0] VR_ADDR_CURVOL  = 8'h70;
    localparam logic [7:0] VR_ADDR_STATUS  = 8'h71;
    // Reset values
    localparam logic [7:0] VR_RST_VOLUME   = 8'h30;
    localparam logic [7:0] VR_RST_NORMAL   = 8'h33;
    localparam logic [7:0] VR_RST_EMERG    = 8'h30;
    localparam logic [7:0] VR_RST_AMCTRL   = 8'h00;
    localparam logic [7:0] VR_RST_AMTIME   = 8'h00;
    // Field positions
    localparam int VR_DN_RATE_LSB = 6;
    localparam int VR_DN_STEP_LSB = 4;
    localparam int VR_UP_RATE_LSB = 2;
    localparam int VR_UP_STEP_LSB = 0;
    localparam int VR_EM_RATE_LSB = 6;
    localparam int VR_EM_STEP_LSB = 4;
    localparam int VR_AM_LEFT_BIT = 0;
    localparam int VR_AM_RIGHT_BIT = 1;
    localparam int VR_AM_LINK_BIT = 2;
    localparam int VR_TL_LSB      = 4;
    localparam int VR_TR_LSB      = 0;
    // Volume codes, 0.5 dB per code
    localparam logic [7:0] VR_CODE_MAX_GAIN = 8'h00;
    localparam logic [7:0] VR_CODE_UNITY    = 8'h30;
    localparam logic [7:0] VR_CODE_FLOOR    = 8'hFE;
    localparam logic [7:0] VR_CODE_MUTE     = 8'hFF;
    localparam logic [1:0] VR_RATE_INSTANT  = 2'h3;
    // Zero-run times at the reference rate, in microseconds
    localparam int VR_REF_KHZ = 96;
    localparam int VR_RUN_US [8] = '{11500, 53000, 106500, 266500,
                                     535000, 1065000, 2665000, 5330000};
    localparam int VR_RUN_W = 19;

    typedef enum logic [1:0]
    {
        VR_IDLE  = 2'b00,
        VR_DOWN  = 2'b01,
        VR_EMERG = 2'b11,
        VR_UP    = 2'b10
    } vr_state_t;

    // Codes moved per update: 4, 2, 1, 0.5 dB
    function automatic logic [3:0] vr_step_codes(input logic [1:0] sel);
        vr_step_codes = 4'h8 >> sel;
    endfunction

    // Sample periods between updates, minus one
    function automatic logic [1:0] vr_rate_m1(input logic [1:0] sel);
        vr_rate_m1 = (sel == 2'h0) ? 2'h0 : (sel == 2'h1) ? 2'h1 : 2'h3;
    endfunction

    // Zero samples needed; counted in samples, so it scales with the rate
    function automatic logic [VR_RUN_W-1:0] vr_run_len(input logic [2:0] sel);
        vr_run_len = VR_RUN_W'(VR_RUN_US[sel] * VR_REF_KHZ / 1000);
    endfunction
endpackage
`default_nettype wire

// *** design/vr_zero_if.sv ***
// Carrier between the control core and one zero-run detector.
// Assumes all signals live on the system clock.
`timescale 1ns/1ps
`default_nettype none
interface vr_zero_if;
    logic       tick;
    logic       zero;
    logic [2:0] run_sel;
    logic       qualify;

    modport src (output tick, output zero, output run_sel, input qualify);
    modport det (input tick, input zero, input run_sel, output qualify);
endinterface
`default_nettype wire

// *** design/vr_ramp_step.sv ***
// One ramp step: moves the current code toward the target, clamped at it.
// Assumes the caller decides when a step is due; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module vr_ramp_step
    import vr_pkg::*;
(
    input  wire logic [7:0] cur,
    input  wire logic [7:0] target,
    input  wire logic [1:0] step_sel,
    input  wire logic       instant,
    output logic      [7:0] nxt
);
    logic [8:0] sum_w;
    logic [8:0] dif_w;
    logic [7:0] down_w;
    logic [7:0] up_w;

    // Clamp in a wider sum so a big step near the end cannot wrap
    assign sum_w  = {1'b0, cur} + {5'h0, vr_step_codes(step_sel)};
    assign dif_w  = {1'b0, cur} - {5'h0, vr_step_codes(step_sel)};
    assign down_w = (sum_w >= {1'b0, target}) ? target : sum_w[7:0]; // R14
    assign up_w   = (dif_w[8] || dif_w[7:0] <= target) ? target : dif_w[7:0]; // R14
    assign nxt    = instant ? target : (cur < target) ? down_w : (cur > target) ? up_w : cur;
endmodule
`default_nettype wire

// *** design/vr_zero_run.sv ***
// Counts consecutive zero samples of one channel and flags a long enough run.
// Assumes the zero flag is valid on each sample strobe.
`timescale 1ns/1ps
`default_nettype none
module vr_zero_run
    import vr_pkg::*;
#(
    parameter int RUN_SHIFT = 0
)
(
    input  wire logic  clk,
    input  wire logic  rst_b,
    vr_zero_if.det     zi
);
    logic [VR_RUN_W-1:0] cnt_reg;
    logic [VR_RUN_W-1:0] cnt_next;
    logic [VR_RUN_W-1:0] limit_w;

    // Beyond ten the shortest run would round down to zero samples
    if (RUN_SHIFT < 0 || RUN_SHIFT > 10)
    begin : g_bad_shift
        $error("RUN_SHIFT out of range");
    end

    // Shift only exists to shorten runs in simulation
    assign limit_w  = vr_run_len(zi.run_sel) >> RUN_SHIFT;
    assign cnt_next = !zi.tick ? cnt_reg : !zi.zero ? '0 :
                      (cnt_reg < limit_w) ? cnt_reg + 1'b1 : cnt_reg; // R13
    assign zi.qualify = (cnt_reg >= limit_w); // R13

    // Run counter, saturating at the limit
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_run_rise_zero: assert property ($rose(zi.qualify) |-> $past(zi.tick && zi.zero) || $changed(zi.run_sel)) // R13
        else $error("qualify rose without a zero sample");
    chk_run_break: assert property (zi.tick && !zi.zero |=> !zi.qualify || limit_w == '0) // R13
        else $error("nonzero sample did not clear qualify");
endmodule
`default_nettype wire

// *** design/vr_volume_ramp.sv ***
// Volume ramp, emergency ramp-down and auto-mute control with its registers.
// Assumes SAMPLE_TICK, EMERG_DOWN and the zero flags come from logic on CLK_SYS.
`timescale 1ns/1ps
`default_nettype none
module vr_volume_ramp
    import vr_pkg::*;
#(
    parameter int RUN_SHIFT = 0
)
(
    input  wire logic       CLK_SYS,
    input  wire logic       RST_B,
    input  wire logic       REG_WR,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    input  wire logic       SAMPLE_TICK,
    input  wire logic       EMERG_DOWN,
    input  wire logic       ZERO_L,
    input  wire logic       ZERO_R,
    output logic      [7:0] VOLUME_CODE,
    output logic            FULL_MUTE,
    output logic            MUTE_L,
    output logic            MUTE_R,
    output logic            RAMP_BUSY
);
    logic [7:0] volume_reg;
    logic [7:0] normal_reg;
    logic [7:0] emerg_reg;
    logic [7:0] amctrl_reg;
    logic [7:0] amtime_reg;
    logic [7:0] vol_cur_reg;
    logic [7:0] vol_cur_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       full_mute_reg;
    logic       mute_l_reg;
    logic       mute_l_next;
    logic       mute_r_reg;
    logic       mute_r_next;
    logic [1:0] tick_cnt_reg;
    logic [1:0] tick_cnt_next;
    logic       busy_reg;
    logic       busy_next;
    vr_state_t  st_reg;
    vr_state_t  st_next;

    logic [7:0] target_w;
    logic [1:0] rate_w;
    logic [1:0] step_w;
    logic       instant_w;
    logic       fire_w;
    logic       move_w;
    logic [7:0] step_out_w;
    logic       q_l_w;
    logic       q_r_w;
    logic       en_l_w;
    logic       en_r_w;
    logic       link_w;
    logic [7:0] status_w;

    // Register write strobes
    logic wr_vol_w;
    logic wr_nrm_w;
    logic wr_emg_w;
    logic wr_amc_w;
    logic wr_amt_w;

    assign wr_vol_w = REG_WR && REG_ADDR == VR_ADDR_VOLUME;
    assign wr_nrm_w = REG_WR && REG_ADDR == VR_ADDR_NORMAL;
    assign wr_emg_w = REG_WR && REG_ADDR == VR_ADDR_EMERG;
    assign wr_amc_w = REG_WR && REG_ADDR == VR_ADDR_AMCTRL;
    assign wr_amt_w = REG_WR && REG_ADDR == VR_ADDR_AMTIME;

    // Reserved bits are kept as written so software reads back its value
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            volume_reg <= VR_RST_VOLUME; // R2
            normal_reg <= VR_RST_NORMAL;
            emerg_reg  <= VR_RST_EMERG;
            amctrl_reg <= VR_RST_AMCTRL;
            amtime_reg <= VR_RST_AMTIME;
        end
        else
        begin
            if (wr_vol_w)
                volume_reg <= REG_WDATA;
            if (wr_nrm_w)
                normal_reg <= REG_WDATA;
            if (wr_emg_w)
                emerg_reg <= REG_WDATA;
            if (wr_amc_w)
                amctrl_reg <= REG_WDATA;
            if (wr_amt_w)
                amtime_reg <= REG_WDATA;
        end
    end

    // Status view packs the flags above the two state bits
    assign status_w = {3'h0, mute_r_reg, mute_l_reg, full_mute_reg, st_reg};

    // Read mux; unmapped offsets read as zero
    assign rdata_next =
        (REG_ADDR == VR_ADDR_VOLUME) ? volume_reg :
        (REG_ADDR == VR_ADDR_NORMAL) ? normal_reg :
        (REG_ADDR == VR_ADDR_EMERG)  ? emerg_reg  :
        (REG_ADDR == VR_ADDR_AMCTRL) ? amctrl_reg :
        (REG_ADDR == VR_ADDR_AMTIME) ? amtime_reg :
        (REG_ADDR == VR_ADDR_CURVOL) ? vol_cur_reg :
        (REG_ADDR == VR_ADDR_STATUS) ? status_w   :
        8'h00;

    // Emergency forces the target to full mute; otherwise software's code
    assign target_w = EMERG_DOWN ? VR_CODE_MUTE : volume_reg; // R8

    // Mode choice; a higher code means less gain, so down means code rising
    assign st_next = (vol_cur_reg == target_w) ? VR_IDLE :
                     EMERG_DOWN ? VR_EMERG :
                     (vol_cur_reg < target_w) ? VR_DOWN : VR_UP;

    // Each mode takes its own rate and step field
    assign rate_w = (st_reg == VR_EMERG) ? emerg_reg[VR_EM_RATE_LSB +: 2] : // R8
                    (st_reg == VR_DOWN)  ? normal_reg[VR_DN_RATE_LSB +: 2] : // R4
                    normal_reg[VR_UP_RATE_LSB +: 2]; // R6
    assign step_w = (st_reg == VR_EMERG) ? emerg_reg[VR_EM_STEP_LSB +: 2] : // R9
                    (st_reg == VR_DOWN)  ? normal_reg[VR_DN_STEP_LSB +: 2] : // R5
                    normal_reg[VR_UP_STEP_LSB +: 2]; // R7

    // Instant setting jumps at once without waiting for a sample strobe
    assign instant_w = (rate_w == VR_RATE_INSTANT);
    assign fire_w    = SAMPLE_TICK && tick_cnt_reg == vr_rate_m1(rate_w); // R4 R6 R8
    assign move_w    = (st_reg != VR_IDLE) && (instant_w || fire_w);

    vr_ramp_step u_step
    (
        .cur      (vol_cur_reg),
        .target   (target_w),
        .step_sel (step_w),
        .instant  (instant_w),
        .nxt      (step_out_w)
    );

    assign vol_cur_next = move_w ? step_out_w : vol_cur_reg; // R14

    // Period counter restarts on every mode change so the first step waits a full period
    assign tick_cnt_next = (st_next != st_reg) ? 2'h0 :
                           fire_w ? 2'h0 :
                           SAMPLE_TICK ? tick_cnt_reg + 2'h1 : tick_cnt_reg;

    // Busy gets its own flop in step with the mode register, so the pin cannot glitch
    assign busy_next = (st_next != VR_IDLE);

    // Ramp state, applied code and update pacing
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            st_reg       <= VR_IDLE;
            vol_cur_reg  <= VR_RST_VOLUME; // R2
            tick_cnt_reg <= 2'h0;
            busy_reg     <= 1'b0;
        end
        else
        begin
            st_reg       <= st_next;
            vol_cur_reg  <= vol_cur_next;
            tick_cnt_reg <= tick_cnt_next;
            busy_reg     <= busy_next;
        end
    end

    // Zero-run detectors, one per channel
    vr_zero_if zif[2] ();

    assign zif[0].tick    = SAMPLE_TICK;
    assign zif[0].zero    = ZERO_L;
    assign zif[0].run_sel = amtime_reg[VR_TL_LSB +: 3]; // R13
    assign zif[1].tick    = SAMPLE_TICK;
    assign zif[1].zero    = ZERO_R;
    assign zif[1].run_sel = amtime_reg[VR_TR_LSB +: 3]; // R13

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_zero
            vr_zero_run #(.RUN_SHIFT(RUN_SHIFT)) u_run
            (
                .clk   (CLK_SYS),
                .rst_b (RST_B),
                .zi    (zif[g])
            );
        end
    endgenerate

    assign q_l_w  = zif[0].qualify;
    assign q_r_w  = zif[1].qualify;
    assign en_l_w = amctrl_reg[VR_AM_LEFT_BIT];
    assign en_r_w = amctrl_reg[VR_AM_RIGHT_BIT];
    assign link_w = amctrl_reg[VR_AM_LINK_BIT];

    // With linking, one silent channel alone never mutes anything
    assign mute_l_next = en_l_w && q_l_w && (!link_w || q_r_w); // R10 R12
    assign mute_r_next = en_r_w && q_r_w && (!link_w || q_l_w); // R11 R12

    // Output flops; the mute flag follows the applied code
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            full_mute_reg <= 1'b0;
            mute_l_reg    <= 1'b0;
            mute_r_reg    <= 1'b0;
            rdata_reg     <= 8'h00;
        end
        else
        begin
            full_mute_reg <= (vol_cur_next == VR_CODE_MUTE); // R3
            mute_l_reg    <= mute_l_next;
            mute_r_reg    <= mute_r_next;
            rdata_reg     <= rdata_next;
        end
    end

    // One code drives both channels, so a single output carries it
    assign VOLUME_CODE = vol_cur_reg; // R1
    assign FULL_MUTE   = full_mute_reg;
    assign MUTE_L      = mute_l_reg;
    assign MUTE_R      = mute_r_reg;
    assign RAMP_BUSY   = busy_reg;
    assign REG_RDATA   = rdata_reg;

    // Checks and coverage
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);

    chk_mute_code: assert property (FULL_MUTE == (VOLUME_CODE == VR_CODE_MUTE)) // R3
        else $error("full mute flag disagrees with applied code");
    chk_left_gate: assert property (!$past(en_l_w) |-> !MUTE_L) // R10
        else $error("left muted while its enable is clear");
    chk_right_gate: assert property (!$past(en_r_w) |-> !MUTE_R) // R11
        else $error("right muted while its enable is clear");
    chk_link_pair: assert property ($past(link_w && en_l_w && en_r_w) && MUTE_L |-> MUTE_R) // R12
        else $error("linked channels muted apart");
    chk_down_step: assert property (st_reg == VR_DOWN && !instant_w && move_w && vol_cur_reg < target_w // R5
        |=> VOLUME_CODE - $past(VOLUME_CODE) <= $past({4'h0, vr_step_codes(step_w)}))
        else $error("normal ramp down step too large");
    chk_up_step: assert property (st_reg == VR_UP && !instant_w && move_w && vol_cur_reg > target_w // R7
        |=> $past(VOLUME_CODE) - VOLUME_CODE <= $past({4'h0, vr_step_codes(step_w)}))
        else $error("ramp up step too large");
    chk_emerg_step: assert property (st_reg == VR_EMERG && !instant_w && move_w && EMERG_DOWN // R9
        |=> VOLUME_CODE - $past(VOLUME_CODE) <= $past({4'h0, vr_step_codes(step_w)}))
        else $error("emergency step too large");
    chk_paced_move: assert property (VOLUME_CODE != $past(VOLUME_CODE) // R4
        |-> $past(instant_w) || $past(fire_w))
        else $error("code moved without a due update");
    chk_up_instant: assert property (st_reg == VR_UP && instant_w |=> VOLUME_CODE == $past(target_w)) // R6
        else $error("instant restore missed target");
    chk_emerg_goal: assert property (st_reg == VR_EMERG && EMERG_DOWN // R8
        |=> VOLUME_CODE > $past(VOLUME_CODE) || VOLUME_CODE == $past(VOLUME_CODE))
        else $error("emergency ramp raised the gain");
    chk_no_overshoot: assert property (st_reg == VR_DOWN && $stable(target_w) // R14
        |=> VOLUME_CODE <= $past(target_w))
        else $error("ramp down passed the target");
    chk_unity_code: assert property (VOLUME_CODE == VR_CODE_UNITY && st_reg == VR_IDLE // R2
        |-> $past(target_w) == VR_CODE_UNITY)
        else $error("idle at unity without unity target");

    // Instant codes, upward clamp, pacing and register views
    chk_down_instant: assert property (st_reg == VR_DOWN && instant_w && vol_cur_reg < target_w // R4
        |=> VOLUME_CODE == $past(target_w))
        else $error("instant ramp down missed target");
    chk_emerg_instant: assert property (st_reg == VR_EMERG && instant_w && EMERG_DOWN // R8
        |=> VOLUME_CODE == VR_CODE_MUTE)
        else $error("instant emergency did not mute");
    chk_emerg_entry: assert property (EMERG_DOWN && VOLUME_CODE != VR_CODE_MUTE |=> st_reg == VR_EMERG) // R8
        else $error("emergency did not take over the ramp");
    chk_up_no_overshoot: assert property (st_reg == VR_UP && $stable(target_w) // R14
        |=> VOLUME_CODE >= $past(target_w))
        else $error("ramp up passed the target");
    chk_tick_pacing: assert property (!instant_w && !SAMPLE_TICK |=> $stable(VOLUME_CODE)) // R6
        else $error("code moved between sample periods");
    chk_idle_still: assert property ($past(st_reg == VR_IDLE) |-> $stable(VOLUME_CODE)) // R14
        else $error("code moved while idle");
    chk_busy_pin: assert property (RAMP_BUSY == (st_reg != VR_IDLE)) // R14
        else $error("busy pin disagrees with ramp mode");
    chk_indep_mute: assert property ($past(!link_w && en_l_w && q_l_w) |-> MUTE_L) // R12
        else $error("unlinked left channel not muted");
    chk_link_wait: assert property ($past(link_w && !q_r_w) |-> !MUTE_L) // R12
        else $error("linked left muted before right qualified");
    chk_curvol_view: assert property ($past(REG_ADDR == VR_ADDR_CURVOL) |-> REG_RDATA == $past(vol_cur_reg)) // R1
        else $error("current code view is stale");
    chk_mute_view: assert property ($past(REG_ADDR == VR_ADDR_STATUS) |-> REG_RDATA[2] == $past(full_mute_reg)) // R3
        else $error("status view lost the mute flag");

    cov_emerg_mute: cover property (st_reg == VR_EMERG ##[1:600] FULL_MUTE);
    cov_up_done: cover property (st_reg == VR_UP ##1 st_reg == VR_IDLE);
    cov_link_mute: cover property (link_w && MUTE_L && MUTE_R);
    cov_slow_rate: cover property (st_reg == VR_DOWN && rate_w == 2'h2 && fire_w);
    cov_instant_up: cover property (st_reg == VR_UP && instant_w ##1 VOLUME_CODE == target_w);
endmodule
`default_nettype wire

// *** verif/vr_volume_ramp_tb.sv ***
// Self-checking bench for the volume ramp and auto-mute block.
// Assumes vr_pkg and the design files are compiled first; drives all ports itself.
`timescale 1ns/1ps
`default_nettype none
module vr_volume_ramp_tb
    import vr_pkg::*;
;
    logic       clk_sys = 1'b0;
    logic       rst_b = 1'b0;
    logic       reg_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic       sample_tick = 1'b0;
    logic       emerg_down = 1'b0;
    logic       zero_l = 1'b0;
    logic       zero_r = 1'b0;
    logic [7:0] volume_code;
    logic       full_mute;
    logic       mute_l;
    logic       mute_r;
    logic       ramp_busy;
    int         n_mismatch = 0;
    int         samples_checked = 0;
    int         n_cyc = 0;
    logic [7:0] cur = 8'h30;

    // Short zero-run limits: selector 0 needs 1 sample, selector 1 needs 4
    vr_volume_ramp #(.RUN_SHIFT(10)) i_dut (
        .CLK_SYS     (clk_sys),
        .RST_B       (rst_b),
        .REG_WR      (reg_wr),
        .REG_ADDR    (reg_addr),
        .REG_WDATA   (reg_wdata),
        .REG_RDATA   (reg_rdata),
        .SAMPLE_TICK (sample_tick),
        .EMERG_DOWN  (emerg_down),
        .ZERO_L      (zero_l),
        .ZERO_R      (zero_r),
        .VOLUME_CODE (volume_code),
        .FULL_MUTE   (full_mute),
        .MUTE_L      (mute_l),
        .MUTE_R      (mute_r),
        .RAMP_BUSY   (ramp_busy)
    );

    // 100 MHz system clock
    always #5 clk_sys = ~clk_sys;

    // Hang guard; the whole run needs well under two thousand cycles
    always @(posedge clk_sys)
    begin
        n_cyc++;
        if (n_cyc == 20000)
        begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic summarize();
        $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Inputs always move 1 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // One write, then a quiet cycle so the strobe never turns around in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask

    // Read data follows the address one edge later
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        cyc(1);
        check("read", reg_rdata, exp);
    endtask

    // One sample period strobe, then idle cycles so each tick stands apart
    task automatic tick(input logic zl, input logic zr);
        sample_tick = 1'b1;
        zero_l = zl;
        zero_r = zr;
        cyc(1);
        sample_tick = 1'b0;
        zero_l = 1'b0;
        zero_r = 1'b0;
        cyc(2);
    endtask

    // Expected step of one update, clamped at the target so it never overshoots
    function automatic logic [7:0] step_to(input logic [7:0] c, input logic [7:0] t, input logic [1:0] s);
        logic [7:0] d;
        d = 8'h08 >> s;
        if (t < c)
            step_to = (c - t > d) ? c - d : t;
        else
            step_to = (t - c > d) ? c + d : t;
    endfunction

    // Program the normal ramp, change the target and follow every update
    task automatic ramp(input logic [7:0] cfg, input logic [7:0] tgt);
        logic [1:0] rate;
        logic [1:0] stp;
        logic       up;
        up = tgt < cur;
        rate = up ? cfg[3:2] : cfg[7:6];
        stp = up ? cfg[1:0] : cfg[5:4];
        wr(VR_ADDR_NORMAL, cfg);
        wr(VR_ADDR_VOLUME, tgt);
        cyc(3);
        if (rate == 2'h3)
        begin
            cur = tgt;
            check("instant", volume_code, cur);
        end
        else
        begin
            check("busy", {7'h00, ramp_busy}, 8'h01);
            while (cur != tgt)
            begin
                repeat ((1 << rate) - 1) tick(1'b0, 1'b0);
                check("hold", volume_code, cur);
                tick(1'b0, 1'b0);
                cur = step_to(cur, tgt, stp);
                check("step", volume_code, cur);
            end
            tick(1'b0, 1'b0);
            check("settled", volume_code, tgt);
        end
        cyc(2);
        check("idle", {7'h00, ramp_busy}, 8'h00);
        check("full mute", {7'h00, full_mute}, {7'h00, tgt == 8'hFF});
        rd(VR_ADDR_CURVOL, cur);
    endtask

    // Emergency ramp toward mute with its own settings, then recovery
    task automatic emg(input logic [7:0] cfg, input int n);
        wr(VR_ADDR_EMERG, cfg);
        emerg_down = 1'b1;
        cyc(3);
        if (cfg[7:6] == 2'h3)
            cur = 8'hFF;
        else
            repeat (n)
            begin
                repeat ((1 << cfg[7:6]) - 1) tick(1'b0, 1'b0);
                check("emerg hold", volume_code, cur);
                tick(1'b0, 1'b0);
                cur = step_to(cur, 8'hFF, cfg[5:4]);
                check("emerg step", volume_code, cur);
            end
        check("emerg code", volume_code, cur);
        // Once the code sits at mute the ramp has nothing left to do and goes idle
        rd(VR_ADDR_STATUS, {5'h00, cur == 8'hFF, cur == 8'hFF ? 2'b00 : 2'b11});
        rd(VR_ADDR_EMERG, cfg);
        emerg_down = 1'b0;
        cyc(4);
        cur = 8'h30;
        check("recovered", volume_code, cur);
    endtask

    // Main sequence
    initial
    begin
        cyc(8);
        rst_b = 1'b1;
        cyc(1);
        check("reset code", volume_code, VR_CODE_UNITY);
        check("reset mute", {5'h00, full_mute, mute_l, mute_r}, 8'h00);
        rd(VR_ADDR_VOLUME, 8'h30);
        rd(VR_ADDR_NORMAL, 8'h33);
        rd(VR_ADDR_EMERG, 8'h30);
        rd(VR_ADDR_AMCTRL, 8'h00);
        rd(VR_ADDR_AMTIME, 8'h00);
        wr(8'h52, 8'h5A);
        rd(8'h52, 8'h00);
        wr(VR_ADDR_CURVOL, 8'h55);
        rd(VR_ADDR_CURVOL, 8'h30);
        // Every rate code in both directions, step codes 0/2/3 down and 0/1/2 up, then mute and restore
        ramp(8'h33, 8'h34);
        ramp(8'h43, 8'h45);
        ramp(8'h09, 8'h3A);
        ramp(8'hA6, 8'h42);
        ramp(8'hA6, 8'h36);
        ramp(8'h00, 8'h20);
        ramp(8'h00, 8'h00);
        ramp(8'hFF, 8'hFE);
        ramp(8'hFF, 8'hFF);
        ramp(8'hFF, 8'h30);
        emg(8'h2A, 3);
        emg(8'h90, 2);
        emg(8'h70, 2);
        emg(8'h00, 2);
        emg(8'hC0, 0);
        // Auto mute: enables, link and run length
        wr(VR_ADDR_AMCTRL, 8'h01);
        tick(1'b1, 1'b1);
        check("left only", {6'h00, mute_l, mute_r}, 8'h02);
        wr(VR_ADDR_AMCTRL, 8'h02);
        cyc(2);
        check("right only", {6'h00, mute_l, mute_r}, 8'h01);
        tick(1'b0, 1'b0);
        wr(VR_ADDR_AMCTRL, 8'h07);
        tick(1'b1, 1'b0);
        check("link one", {6'h00, mute_l, mute_r}, 8'h00);
        tick(1'b1, 1'b1);
        check("link both", {6'h00, mute_l, mute_r}, 8'h03);
        wr(VR_ADDR_AMCTRL, 8'h03);
        tick(1'b0, 1'b1);
        check("independent", {6'h00, mute_l, mute_r}, 8'h01);
        wr(VR_ADDR_AMTIME, 8'h10);
        rd(VR_ADDR_AMTIME, 8'h10);
        wr(VR_ADDR_AMCTRL, 8'h01);
        repeat (3) tick(1'b1, 1'b0);
        check("short run", {7'h00, mute_l}, 8'h00);
        tick(1'b1, 1'b0);
        check("long run", {7'h00, mute_l}, 8'h01);
        check("code kept", volume_code, 8'h30);
        summarize();
    end
endmodule
`default_nettype wire
